// ===== verilog/urx_pkg.sv
package urx_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [1:0] ADDR_DATA = 2'h0;
	localparam logic [1:0] ADDR_CSA  = 2'h1;
	localparam logic [1:0] ADDR_CSB  = 2'h2;
	localparam logic [1:0] ADDR_CSC  = 2'h3;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CSA_DONE      = 7;
	localparam int CSA_FRAME_ERR = 4;
	localparam int CSA_OVERRUN   = 3;
	localparam int CSA_PAR_ERR   = 2;
	localparam int CSA_DOUBLE    = 1;
	localparam int CSB_DONE_IE   = 7;
	localparam int CSB_RX_ON     = 4;
	localparam int CSB_SIZE2     = 2;
	localparam int CSB_RX_NINTH  = 1;
	localparam int CSB_TX_NINTH  = 0;
	localparam int CSC_PEN     = 5;
	localparam int CSC_PODD    = 4;
	localparam int CSC_STOP    = 3;
	localparam int CSC_SIZE_LO = 1;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CSA_RST = 8'h00;
	localparam logic [7:0] CSB_RST = 8'h00;
	localparam logic [7:0] CSC_RST = 8'h06;

	// ------------------------------------------------------------
	// Timing, frame sizes and buffer depth
	// ------------------------------------------------------------
	localparam int CLK_HZ     = 50_000_000;
	localparam int BAUD_HZ    = 9600;
	localparam int SAMPLE_DIV = CLK_HZ / (BAUD_HZ * 16);
	localparam logic [4:0] SPB_NORMAL   = 5'h10;
	localparam logic [4:0] SPB_DOUBLE   = 5'h08;
	localparam logic [4:0] VOTE_LO_NORM = 5'h08;
	localparam logic [4:0] VOTE_HI_NORM = 5'h0a;
	localparam logic [4:0] VOTE_LO_DBL  = 5'h04;
	localparam logic [4:0] VOTE_HI_DBL  = 5'h06;
	localparam logic [3:0] BITS_NINE    = 4'h9;
	localparam logic [3:0] BITS_FIVE    = 4'h5;
	localparam logic [1:0] FIFO_FULL    = 2'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {URX_IDLE, URX_START, URX_BITS} urx_state_type;

	typedef struct packed {
		logic       double_speed_select;
		logic       par_en;
		logic       par_odd;
		logic [3:0] nbits;
	} urx_cfg_type;

	typedef struct packed {
		logic [8:0] data;
		logic       frame_error;
		logic       overrun;
		logic       parity_error;
	} urx_entry_type;

endpackage

// ===== verilog/urx_sampler.sv
`timescale 1ns/100ps
module urx_sampler #(
	parameter int DIV = urx_pkg::SAMPLE_DIV
) (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   enable,
	input  wire logic                   rxd,
	input  wire urx_pkg::urx_cfg_type   cfg,
	output      logic                   start_pulse,
	output      logic                   done,
	output      urx_pkg::urx_entry_type frame
);

	// ------------------------------------------------------------
	// Sample rate divider
	// ------------------------------------------------------------
	logic [15:0]                 div_cnt;
	logic                        tick;
	urx_pkg::urx_state_type      state;
	logic [4:0]                  smp;
	logic [4:0]                  cur;
	logic [4:0]                  spb;
	logic [4:0]                  vlo;
	logic [4:0]                  vhi;
	logic [1:0]                  votes;
	logic                        maj;
	logic [3:0]                  bitn;
	logic [8:0]                  data;
	logic                        par_bit;
	logic                        idle_hi;

	assign tick = div_cnt == 16'(DIV - 1);

	always_ff @(posedge clock) begin
		if (rst || !enable || tick) begin
			div_cnt <= 16'h0000;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Sample windows and vote
	// ------------------------------------------------------------
	assign spb = cfg.double_speed_select ? urx_pkg::SPB_DOUBLE : urx_pkg::SPB_NORMAL;
	assign vlo = cfg.double_speed_select ? urx_pkg::VOTE_LO_DBL : urx_pkg::VOTE_LO_NORM;
	assign vhi = cfg.double_speed_select ? urx_pkg::VOTE_HI_DBL : urx_pkg::VOTE_HI_NORM;
	assign cur = (smp == spb) ? 5'h01 : smp + 5'h01;
	// Two of three centre samples win, which filters short spikes
	assign maj = (votes[1] & votes[0]) | (votes[1] & rxd) | (votes[0] & rxd);

	// ------------------------------------------------------------
	// Frame state machine
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst || !enable) begin
			state       <= urx_pkg::URX_IDLE;
			smp         <= 5'h00;
			bitn        <= 4'h0;
			votes       <= 2'h0;
			data        <= 9'h000;
			par_bit     <= 1'b0;
			idle_hi     <= 1'b0;
			start_pulse <= 1'b0;
			done        <= 1'b0;
			frame       <= '0;
		end else begin
			start_pulse <= 1'b0;
			done        <= 1'b0;
			if (tick) begin
				unique case (state)
				urx_pkg::URX_IDLE: begin
					idle_hi <= rxd;
					if (idle_hi && !rxd) begin
						state <= urx_pkg::URX_START;
						smp   <= 5'h01;
						data  <= 9'h000;
					end
				end
				urx_pkg::URX_START: begin
					smp <= cur;
					if (cur >= vlo && cur < vhi) begin
						votes <= {votes[0], rxd};
					end
					if (cur == vhi) begin
						if (maj) begin
							state   <= urx_pkg::URX_IDLE;
							idle_hi <= 1'b1;
						end else begin
							state       <= urx_pkg::URX_BITS;
							bitn        <= 4'h0;
							start_pulse <= 1'b1;
						end
					end
				end
				urx_pkg::URX_BITS: begin
					smp <= cur;
					if (cur >= vlo && cur < vhi) begin
						votes <= {votes[0], rxd};
					end
					if (cur == vhi) begin
						bitn <= bitn + 4'h1;
						if (bitn < cfg.nbits) begin
							// Unused high bits stay zero from the start bit
							data[bitn] <= maj;
						end else if (cfg.par_en && bitn == cfg.nbits) begin
							par_bit <= maj;
						end else begin
							// Only the first stop bit is looked at
							state      <= urx_pkg::URX_IDLE;
							idle_hi    <= rxd;
							done       <= 1'b1;
							frame.data         <= data;
							frame.frame_error  <= ~maj;
							frame.overrun      <= 1'b0;
							frame.parity_error <= cfg.par_en & (par_bit ^ (^data) ^ cfg.par_odd);
						end
					end
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_start_vote;
		tick && state == urx_pkg::URX_START && cur == vhi;
	endsequence

	property p_start_reject;
		s_start_vote ##0 maj |=> state == urx_pkg::URX_IDLE && !start_pulse;
	endproperty
	a_start_reject: assert property (p_start_reject) else $error("noise start kept");

	property p_stop_vote;
		tick && state == urx_pkg::URX_BITS && cur == vhi
			&& bitn == cfg.nbits + 4'(cfg.par_en)
			|=> done && frame.frame_error == !$past(maj);
	endproperty
	a_stop_vote: assert property (p_stop_vote) else $error("stop bit vote wrong");

	property p_disable_now;
		!enable |=> state == urx_pkg::URX_IDLE && !done;
	endproperty
	a_disable_now: assert property (p_disable_now) else $error("disable not immediate");

	property p_sample_range;
		state != urx_pkg::URX_IDLE |-> smp <= spb && smp != 5'h00;
	endproperty
	a_sample_range: assert property (p_sample_range) else $error("sample count out of range");

endmodule

// ===== verilog/urx_top.sv
`timescale 1ns/100ps
module urx_top #(
	parameter int DIV = urx_pkg::SAMPLE_DIV
) (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output      logic [7:0] rdata,
	input  wire logic       rxd,
	output      logic       irq,
	output      logic       rxd_owned
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic                   rxd_meta;
	logic                   rxd_sync;
	logic                   double_speed_select;
	logic                   receive_complete_irq_enable;
	logic                   receiver_enable;
	logic                   txb9;
	logic                   size2;
	logic                   par_en;
	logic                   par_odd;
	logic                   stop2;
	logic [1:0]             size_lo;
	urx_pkg::urx_cfg_type   cfg;
	logic                   start_pulse;
	logic                   done;
	urx_pkg::urx_entry_type sframe;
	urx_pkg::urx_entry_type mem [2];
	logic                   rptr;
	logic [1:0]             cnt;
	logic [1:0]             next_cnt;
	logic                   pend_valid;
	urx_pkg::urx_entry_type pend;
	logic                   lost;
	urx_pkg::urx_entry_type head;
	urx_pkg::urx_entry_type push_entry;
	logic                   wr_csa;
	logic                   wr_csb;
	logic                   wr_csc;
	logic                   rd_data;
	logic                   pop;
	logic                   can_push;
	logic                   push;
	logic                   overrun;
	logic                   wptr;
	logic                   receive_complete_flag;
	logic                   frame_error_flag;
	logic                   overrun_flag;
	logic                   parity_error_flag;
	logic [7:0]             csa_val;
	logic [7:0]             csb_val;
	logic [7:0]             csc_val;
	logic [7:0]             data_val;
	logic [7:0]             read_val;

	// ------------------------------------------------------------
	// Input synchroniser
	// ------------------------------------------------------------
	// The pin is asynchronous to the clock; two stages before use
	always_ff @(posedge clock) begin
		if (rst) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
		end else begin
			rxd_meta <= rxd;
			rxd_sync <= rxd_meta;
		end
	end

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	assign wr_csa  = wr && addr == urx_pkg::ADDR_CSA;
	assign wr_csb  = wr && addr == urx_pkg::ADDR_CSB;
	assign wr_csc  = wr && addr == urx_pkg::ADDR_CSC;
	assign rd_data = rd && addr == urx_pkg::ADDR_DATA;

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			double_speed_select         <= urx_pkg::CSA_RST[urx_pkg::CSA_DOUBLE];
			receive_complete_irq_enable <= urx_pkg::CSB_RST[urx_pkg::CSB_DONE_IE];
			receiver_enable             <= urx_pkg::CSB_RST[urx_pkg::CSB_RX_ON];
			size2   <= urx_pkg::CSB_RST[urx_pkg::CSB_SIZE2];
			txb9    <= urx_pkg::CSB_RST[urx_pkg::CSB_TX_NINTH];
			par_en  <= urx_pkg::CSC_RST[urx_pkg::CSC_PEN];
			par_odd <= urx_pkg::CSC_RST[urx_pkg::CSC_PODD];
			stop2   <= urx_pkg::CSC_RST[urx_pkg::CSC_STOP];
			size_lo <= urx_pkg::CSC_RST[urx_pkg::CSC_SIZE_LO +: 2];
		end else begin
			if (wr_csa) begin
				// Error bit positions are not stored from a write
				double_speed_select <= wdata[urx_pkg::CSA_DOUBLE];
			end
			if (wr_csb) begin
				receive_complete_irq_enable <= wdata[urx_pkg::CSB_DONE_IE];
				receiver_enable             <= wdata[urx_pkg::CSB_RX_ON];
				size2                       <= wdata[urx_pkg::CSB_SIZE2];
				txb9                        <= wdata[urx_pkg::CSB_TX_NINTH];
			end
			if (wr_csc) begin
				par_en  <= wdata[urx_pkg::CSC_PEN];
				par_odd <= wdata[urx_pkg::CSC_PODD];
				stop2   <= wdata[urx_pkg::CSC_STOP];
				size_lo <= wdata[urx_pkg::CSC_SIZE_LO +: 2];
			end
		end
	end

	// Only the first stop bit is checked, so stop2 feeds no receive logic
	assign cfg.double_speed_select = double_speed_select;
	assign cfg.par_en  = par_en;
	assign cfg.par_odd = par_odd;
	assign cfg.nbits   = size2 ? urx_pkg::BITS_NINE : urx_pkg::BITS_FIVE + {2'h0, size_lo};

	// ------------------------------------------------------------
	// Clock and data recovery
	// ------------------------------------------------------------
	urx_sampler #(
		.DIV (DIV)
	) u_sampler (
		.clock       (clock),
		.rst         (rst),
		.enable      (receiver_enable),
		.rxd         (rxd_sync),
		.cfg         (cfg),
		.start_pulse (start_pulse),
		.done        (done),
		.frame       (sframe)
	);

	// ------------------------------------------------------------
	// Two-entry buffer plus waiting shift register
	// ------------------------------------------------------------
	assign head     = mem[rptr];
	assign pop      = rd_data && cnt != 2'h0;
	assign can_push = cnt != urx_pkg::FIFO_FULL || pop;
	assign push     = receiver_enable && (done || pend_valid) && can_push;
	assign overrun  = start_pulse && pend_valid && !can_push;
	assign wptr     = rptr ^ cnt[0];
	assign next_cnt = cnt + 2'(push) - 2'(pop);

	// The overrun mark rides on the next frame that gets in
	always_comb begin
		push_entry     = done ? sframe : pend;
		push_entry.overrun = lost;
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wptr] <= push_entry;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || !receiver_enable) begin
			cnt        <= 2'h0;
			rptr       <= 1'b0;
			pend_valid <= 1'b0;
			pend       <= '0;
			lost       <= 1'b0;
		end else begin
			cnt <= next_cnt;
			if (pop) begin
				rptr <= ~rptr;
			end
			if (overrun) begin
				// The new start bit overwrites the waiting frame
				pend_valid <= 1'b0;
				lost       <= 1'b1;
			end else if (done && !can_push) begin
				pend_valid <= 1'b1;
				pend       <= sframe;
			end else if (push && !done) begin
				pend_valid <= 1'b0;
			end
			if (push) begin
				lost <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Status and read mux
	// ------------------------------------------------------------
	assign receive_complete_flag = cnt != 2'h0;
	assign frame_error_flag      = receive_complete_flag & head.frame_error;
	assign overrun_flag          = receive_complete_flag & head.overrun;
	assign parity_error_flag     = receive_complete_flag & head.parity_error & par_en;

	assign csa_val  = 8'(receive_complete_flag) << urx_pkg::CSA_DONE
	                | 8'(frame_error_flag) << urx_pkg::CSA_FRAME_ERR
	                | 8'(overrun_flag) << urx_pkg::CSA_OVERRUN
	                | 8'(parity_error_flag) << urx_pkg::CSA_PAR_ERR
	                | 8'(double_speed_select) << urx_pkg::CSA_DOUBLE;
	assign csb_val  = 8'(receive_complete_irq_enable) << urx_pkg::CSB_DONE_IE
	                | 8'(receiver_enable) << urx_pkg::CSB_RX_ON
	                | 8'(size2) << urx_pkg::CSB_SIZE2
	                | 8'(receive_complete_flag & head.data[8]) << urx_pkg::CSB_RX_NINTH
	                | 8'(txb9) << urx_pkg::CSB_TX_NINTH;
	assign csc_val  = 8'(par_en) << urx_pkg::CSC_PEN
	                | 8'(par_odd) << urx_pkg::CSC_PODD
	                | 8'(stop2) << urx_pkg::CSC_STOP
	                | 8'(size_lo) << urx_pkg::CSC_SIZE_LO;
	assign data_val = receive_complete_flag ? head.data[7:0] : 8'h00;

	always_comb begin
		unique case (addr)
		urx_pkg::ADDR_DATA: read_val = data_val;
		urx_pkg::ADDR_CSA:  read_val = csa_val;
		urx_pkg::ADDR_CSB:  read_val = csb_val;
		urx_pkg::ADDR_CSC:  read_val = csc_val;
		endcase
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata     <= 8'h00;
			irq       <= 1'b0;
			rxd_owned <= 1'b0;
		end else begin
			rdata     <= rd ? read_val : 8'h00;
			// Error flags are left out of the request on purpose
			irq       <= receive_complete_flag & receive_complete_irq_enable;
			rxd_owned <= receiver_enable;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_rxc_read;
		rd && addr == urx_pkg::ADDR_CSA |=> rdata[urx_pkg::CSA_DONE] == ($past(cnt) != 2'h0);
	endproperty
	a_rxc_read: assert property (p_rxc_read) else $error("receive complete wrong");

	property p_flush;
		!receiver_enable |=> cnt == 2'h0 && !pend_valid;
	endproperty
	a_flush: assert property (p_flush) else $error("buffer not flushed");

	property p_irq_level;
		receiver_enable && receive_complete_irq_enable && receive_complete_flag && !pop
			##1 receiver_enable && receive_complete_irq_enable && receive_complete_flag
			|=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("request dropped");

	property p_irq_cause;
		irq |-> $past(receive_complete_flag) && $past(receive_complete_irq_enable);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("request without data");

	property p_err_write;
		wr_csa && !push && !pop |=> $stable({frame_error_flag, overrun_flag, parity_error_flag});
	endproperty
	a_err_write: assert property (p_err_write) else $error("error flag written");

	property p_overrun;
		overrun |=> lost ##0 !pend_valid;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun missed");

	property p_dor_clear;
		push && !lost ##1 cnt == 2'h1 |-> !overrun_flag;
	endproperty
	a_dor_clear: assert property (p_dor_clear) else $error("overrun not cleared");

	property p_upe_off;
		rd && addr == urx_pkg::ADDR_CSA && !par_en |=> !rdata[urx_pkg::CSA_PAR_ERR];
	endproperty
	a_upe_off: assert property (p_upe_off) else $error("parity flag with check off");

	property p_pop_advance;
		rd_data && cnt == urx_pkg::FIFO_FULL && !push |=> cnt == 2'h1 && rptr != $past(rptr);
	endproperty
	a_pop_advance: assert property (p_pop_advance) else $error("read did not advance");

	property p_pin_release;
		!receiver_enable |=> !rxd_owned;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("pin still owned");

endmodule

// ===== dv/urx_line_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Remote serial transmitter on the receive line
// ------------------------------------------------------------
module urx_line_model #(
	parameter int DIV = 4
) (
	input  wire logic clock,
	output      logic rxd
);
	// Line idles at its pull-up level between frames
	initial rxd = 1'b1;

	// Holds one level for whole sample periods
	task automatic hold(input logic v, input int samples);
		rxd <= v;
		repeat (samples * DIV) @(posedge clock);
	endtask

	// Start, data LSB first, optional parity, one stop bit
	task automatic send(input logic [8:0] d, input int nbits, input int spb, input logic pen,
			input logic podd, input logic pbad, input logic stop_v);
		logic p;
		p = podd;
		@(posedge clock);
		hold(1'b0, spb);
		for (int i = 0; i < nbits; i++) begin
			p = p ^ d[i];
			hold(d[i], spb);
		end
		if (pen) begin
			hold(p ^ pbad, spb);
		end
		hold(stop_v, spb);
		rxd <= 1'b1;
	endtask
endmodule

// ===== dv/urx_top_tb.sv
`timescale 1ns/100ps
module urx_top_tb;
	localparam int DIV = 4;
	logic       clock;
	logic       rst;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       rxd;
	logic       irq;
	logic       rxd_owned;
	int         failures;
	int         comparisons;

	urx_top #(.DIV(DIV)) dut (
		.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rxd(rxd), .irq(irq), .rxd_owned(rxd_owned)
	);
	urx_line_model #(.DIV(DIV)) line (.clock(clock), .rxd(rxd));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// ------------------------------------------------------------
	// Bus and line tasks
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string what);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 check(rdata, exp, what);
	endtask

	task automatic pins(input logic exp_irq, input logic exp_own, input string what);
		repeat (2) @(posedge clock);
		#1 check({6'h00, irq, rxd_owned}, {6'h00, exp_irq, exp_own}, what);
	endtask

	// Margin covers synchroniser and the rest of the stop bit
	task automatic rx(input logic [8:0] d, input int n, input int spb, input logic pen,
			input logic podd, input logic pbad, input logic stop_v);
		line.send(d, n, spb, pen, podd, pbad, stop_v);
		repeat (8) @(posedge clock);
	endtask

	task automatic rx8(input logic [7:0] d);
		rx({1'b0, d}, 8, 16, 1'b0, 1'b0, 1'b0, 1'b1);
	endtask

	task automatic test_done;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Whole run is near 16k cycles; this cuts a hang short
	initial begin
		repeat (60000) @(posedge clock);
		failures++;
		$display("BAD %0t watchdog expired", $time);
		test_done;
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		addr = 2'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		failures = 0;
		comparisons = 0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		rd_chk(urx_pkg::ADDR_CSA, urx_pkg::CSA_RST, "reset a");
		rd_chk(urx_pkg::ADDR_CSB, urx_pkg::CSB_RST, "reset b");
		rd_chk(urx_pkg::ADDR_CSC, urx_pkg::CSC_RST, "reset c");
		pins(1'b0, 1'b0, "pins after reset");
		$display("test reset done");

		wr_reg(urx_pkg::ADDR_CSB, 8'h90);
		pins(1'b0, 1'b1, "pin taken");
		rx8(8'ha5);
		pins(1'b1, 1'b1, "irq raised");
		pins(1'b1, 1'b1, "irq held");
		rd_chk(urx_pkg::ADDR_CSA, 8'h80, "rxc set");
		rd_chk(urx_pkg::ADDR_DATA, 8'ha5, "data");
		rd_chk(urx_pkg::ADDR_CSA, 8'h00, "rxc clear");
		pins(1'b0, 1'b1, "irq drop");
		$display("test basic done");

		wr_reg(urx_pkg::ADDR_CSC, 8'h0e);
		rx(9'h03c, 8, 16, 1'b0, 1'b0, 1'b0, 1'b0);
		wr_reg(urx_pkg::ADDR_CSA, 8'h00);
		rd_chk(urx_pkg::ADDR_CSA, 8'h90, "frame error");
		wr_reg(urx_pkg::ADDR_CSB, 8'h10);
		pins(1'b0, 1'b1, "no error irq");
		rd_chk(urx_pkg::ADDR_DATA, 8'h3c, "fe data");
		wr_reg(urx_pkg::ADDR_CSB, 8'h90);
		$display("test frame error done");

		for (int i = 0; i < 4; i++) begin
			wr_reg(urx_pkg::ADDR_CSC, (i < 2) ? 8'h26 : 8'h36);
			rx(9'h0b7, 8, 16, 1'b1, i >= 2, i % 2 == 0, 1'b1);
			rd_chk(urx_pkg::ADDR_CSA, (i % 2 == 0) ? 8'h84 : 8'h80, "parity");
			rd_chk(urx_pkg::ADDR_DATA, 8'hb7, "parity data");
		end
		wr_reg(urx_pkg::ADDR_CSC, 8'h26);
		rx(9'h0b7, 8, 16, 1'b1, 1'b0, 1'b1, 1'b1);
		wr_reg(urx_pkg::ADDR_CSC, 8'h06);
		rd_chk(urx_pkg::ADDR_CSA, 8'h80, "parity off");
		rd_chk(urx_pkg::ADDR_DATA, 8'hb7, "parity off data");
		$display("test parity done");

		rx8(8'h11);
		rx8(8'h22);
		rx8(8'h33);
		rx8(8'h44);
		rd_chk(urx_pkg::ADDR_CSA, 8'h80, "first head");
		rd_chk(urx_pkg::ADDR_DATA, 8'h11, "first");
		rd_chk(urx_pkg::ADDR_CSA, 8'h80, "second head");
		rd_chk(urx_pkg::ADDR_DATA, 8'h22, "second");
		rd_chk(urx_pkg::ADDR_CSA, 8'h88, "overrun");
		rd_chk(urx_pkg::ADDR_DATA, 8'h44, "after loss");
		rd_chk(urx_pkg::ADDR_CSA, 8'h00, "drained");
		rx8(8'h55);
		rd_chk(urx_pkg::ADDR_CSA, 8'h80, "overrun cleared");
		rd_chk(urx_pkg::ADDR_DATA, 8'h55, "fresh");
		$display("test overrun done");

		wr_reg(urx_pkg::ADDR_CSB, 8'h94);
		rx(9'h1c3, 9, 16, 1'b0, 1'b0, 1'b0, 1'b1);
		rx(9'h0c3, 9, 16, 1'b0, 1'b0, 1'b0, 1'b1);
		rd_chk(urx_pkg::ADDR_CSA, 8'h80, "nine status");
		rd_chk(urx_pkg::ADDR_CSB, 8'h96, "ninth one");
		rd_chk(urx_pkg::ADDR_DATA, 8'hc3, "nine low");
		rd_chk(urx_pkg::ADDR_CSB, 8'h94, "ninth zero");
		rd_chk(urx_pkg::ADDR_DATA, 8'hc3, "nine low 2");
		wr_reg(urx_pkg::ADDR_CSB, 8'h90);
		for (int i = 0; i < 4; i++) begin
			wr_reg(urx_pkg::ADDR_CSC, 8'(i * 2));
			rx(9'h1ff, 5 + i, 16, 1'b0, 1'b0, 1'b0, 1'b1);
			rd_chk(urx_pkg::ADDR_DATA, 8'(8'hff >> (3 - i)), "size mask");
		end
		wr_reg(urx_pkg::ADDR_CSC, 8'h06);
		$display("test sizes done");

		wr_reg(urx_pkg::ADDR_CSA, 8'h02);
		rx(9'h05a, 8, 8, 1'b0, 1'b0, 1'b0, 1'b1);
		rx(9'h0a6, 8, 8, 1'b0, 1'b0, 1'b0, 1'b1);
		rd_chk(urx_pkg::ADDR_CSA, 8'h82, "double speed");
		rd_chk(urx_pkg::ADDR_DATA, 8'h5a, "double data");
		rd_chk(urx_pkg::ADDR_DATA, 8'ha6, "double resync");
		line.hold(1'b0, 3);
		line.hold(1'b1, 16);
		rd_chk(urx_pkg::ADDR_CSA, 8'h02, "double noise");
		wr_reg(urx_pkg::ADDR_CSA, 8'h00);
		line.hold(1'b0, 5);
		line.hold(1'b1, 16);
		rd_chk(urx_pkg::ADDR_CSA, 8'h00, "noise start");
		rx8(8'h69);
		rd_chk(urx_pkg::ADDR_DATA, 8'h69, "after noise");
		$display("test sampling done");

		rx8(8'h12);
		rx8(8'h34);
		fork
			line.send(9'h056, 8, 16, 1'b0, 1'b0, 1'b0, 1'b1);
			begin
				repeat (200) @(posedge clock);
				wr_reg(urx_pkg::ADDR_CSB, 8'h80);
				pins(1'b0, 1'b0, "released");
				rd_chk(urx_pkg::ADDR_CSA, 8'h00, "flushed");
			end
		join
		repeat (20) @(posedge clock);
		wr_reg(urx_pkg::ADDR_CSB, 8'h90);
		repeat (200) @(posedge clock);
		rd_chk(urx_pkg::ADDR_CSA, 8'h00, "frame abandoned");
		rx8(8'h78);
		rd_chk(urx_pkg::ADDR_DATA, 8'h78, "restart");
		$display("test disable done");
		test_done;
	end
endmodule
